/* File: hw/mlus_pkg.sv */
// Shared constants and types for the memory load/unload sequencer
package mlus_pkg;
  localparam int WORD_W     = 6;
  localparam int ADDR_W     = 6;
  localparam int MEM_DEPTH  = 64;
  localparam int CNT_W      = 7;
  localparam int FIFO_DEPTH = 8;
  localparam int REG_AW     = 3;
  localparam int SYNC_W     = 4;

  // Register offsets
  localparam logic [REG_AW-1:0] OFS_CTRL   = 3'h0;
  localparam logic [REG_AW-1:0] OFS_XREG   = 3'h1;
  localparam logic [REG_AW-1:0] OFS_MADDR  = 3'h2;
  localparam logic [REG_AW-1:0] OFS_PCNT   = 3'h3;
  localparam logic [REG_AW-1:0] OFS_INSTR  = 3'h4;
  localparam logic [REG_AW-1:0] OFS_CNTDN  = 3'h5;
  localparam logic [REG_AW-1:0] OFS_STATUS = 3'h6;
  localparam logic [REG_AW-1:0] OFS_MDATA  = 3'h7;

  // Control register fields
  localparam int CTRL_OP_LSB  = 0;
  localparam int CTRL_OP_W    = 3;
  localparam int CTRL_REPEAT  = 3;
  localparam int CTRL_RUN_END = 4;
  localparam int CTRL_SEF     = 5;
  localparam int CTRL_W       = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

  // Pin synchroniser lanes
  localparam int PIN_START  = 0;
  localparam int PIN_CLEAR  = 1;
  localparam int PIN_STOP   = 2;
  localparam int PIN_RESUME = 3;

  localparam logic [2:0]        DIST_WAIT_IN = 3'h5;
  localparam logic [2:0]        DIST_IDLE    = 3'h0;
  localparam logic [WORD_W-1:0] LOAD_CONSECUTIVE = 6'h38;

  typedef enum logic [2:0] {
    MLUS_OP_MAN_IN  = 3'h0,
    MLUS_OP_MAN_OUT = 3'h1,
    MLUS_OP_EXT_LD  = 3'h2,
    MLUS_OP_EXT_UL  = 3'h3,
    MLUS_OP_PROGRAM = 3'h4,
    MLUS_OP_SINGLE  = 3'h5
  } mlus_op_t;

  typedef enum logic [2:0] {
    MLUS_ST_IDLE     = 3'h0,
    MLUS_ST_IN_WAIT  = 3'h1,
    MLUS_ST_OUT_WAIT = 3'h2,
    MLUS_ST_EXT_LD   = 3'h3,
    MLUS_ST_EXT_UL   = 3'h4,
    MLUS_ST_FILL     = 3'h5
  } mlus_state_t;
endpackage

/* File: hw/mlus_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
module mlus_pin_sync #(
  parameter int W = 4
) (
  input  wire logic         ref_clk_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] rise_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] level_reg;
  logic [W-1:0] level_next;

  // Level only moves once stages two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      level_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : level_reg[i];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      s3_reg    <= '0;
      level_reg <= '0;
      rise_o    <= '0;
    end else begin
      s1_reg    <= pin_i;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
      rise_o    <= level_next & ~level_reg;
    end
  end
endmodule

/* File: hw/mlus_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module mlus_fifo #(
  parameter int W = 6,
  parameter int D = 8
) (
  input  wire logic         ref_clk_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] wr_data_i,
  input  wire logic         wr_valid_i,
  output logic              wr_ready_o,
  output logic      [W-1:0] rd_data_o,
  output logic              rd_valid_o,
  input  wire logic         rd_ready_i
);
  localparam int PW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [PW-1:0] wptr_reg;
  logic [PW-1:0] rptr_reg;
  logic [PW:0]   cnt_reg;
  logic          push;
  logic          pop;

  assign wr_ready_o = (cnt_reg != D[PW:0]);
  assign rd_valid_o = (cnt_reg != '0);
  assign rd_data_o  = mem[rptr_reg];
  assign push       = wr_valid_i & wr_ready_o;
  assign pop        = rd_valid_o & rd_ready_i;

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wptr_reg] <= wr_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg == PW'(D - 1)) ? '0 : wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == PW'(D - 1)) ? '0 : rptr_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

/* File: hw/mlus_top.sv */
// Memory load/unload sequencer: panel, reader and printer word transfers
//
// Summary of operation
// - New store replaces old word; zero clears
// - Clear pin clears every register; the reader FIFO is not cleared, so its status bit can stay set
// - Manual input start waits with distributor five
// - Each input start stores X, then advances M
// - Transfer uses M as it stands now
// - Output start copies memory word into X
// - Without resume, one word per start
// - Program start runs from program counter
// - Repeat fill copies X everywhere continuously
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module mlus_top (
  input  wire logic                         ref_clk_i,
  input  wire logic                         srst_i,
  input  wire logic [mlus_pkg::REG_AW-1:0]  reg_addr_i,
  input  wire logic [7:0]                   reg_wdata_i,
  input  wire logic                         reg_wr_i,
  input  wire logic                         reg_rd_i,
  output logic      [7:0]                   reg_rdata_o,
  input  wire logic                         start_pin_i,
  input  wire logic                         clear_pin_i,
  input  wire logic                         stop_pin_i,
  input  wire logic                         resume_pin_i,
  input  wire logic [mlus_pkg::WORD_W-1:0]  rdr_data_i,
  input  wire logic                         rdr_valid_i,
  output logic                              rdr_ready_o,
  output logic      [mlus_pkg::WORD_W-1:0]  prn_data_o,
  output logic                              prn_valid_o,
  output logic      [2:0]                   dist_o,
  output logic                              run_o,
  output logic      [mlus_pkg::ADDR_W-1:0]  run_addr_o
);
  localparam int WW = mlus_pkg::WORD_W;
  localparam int AW = mlus_pkg::ADDR_W;
  localparam int CW = mlus_pkg::CNT_W;

  logic [WW-1:0] mem [mlus_pkg::MEM_DEPTH];
  logic [mlus_pkg::CTRL_W-1:0] ctrl_reg;
  logic [WW-1:0]               x_reg;
  logic [AW-1:0]               m_reg;
  logic [AW-1:0]               p_reg;
  logic [WW-1:0]               i_reg;
  logic [CW-1:0]               c_reg;
  logic                        pend_reg;
  mlus_pkg::mlus_state_t       state_reg;
  mlus_pkg::mlus_state_t       state_next;
  mlus_pkg::mlus_op_t          op;

  logic [mlus_pkg::SYNC_W-1:0] pin_rise;
  logic                        start_p;
  logic                        clr_p;
  logic                        stop_p;
  logic                        resume_p;
  logic                        clr;
  logic [WW-1:0]               fifo_data;
  logic                        fifo_valid;
  logic                        fifo_ready;

  logic          wr_ctrl;
  logic          wr_x;
  logic          wr_m;
  logic          idle_start;
  logic          fill_ok;
  logic          step_in;
  logic          step_out;
  logic          ext_ld_do;
  logic          ext_ul_do;
  logic          fill_do;
  logic          mem_wr;
  logic [WW-1:0] mem_wdata;
  logic [WW-1:0] mem_rd;
  logic          m_inc;
  logic          ext_last;
  logic          run_next;

  mlus_pin_sync #(
    .W (mlus_pkg::SYNC_W)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .pin_i     ({resume_pin_i, stop_pin_i, clear_pin_i, start_pin_i}),
    .rise_o    (pin_rise)
  );

  // Reader words queue here so the tape can run ahead of the store steps
  mlus_fifo #(
    .W (WW),
    .D (mlus_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i  (ref_clk_i),
    .srst_i     (srst_i),
    .wr_data_i  (rdr_data_i),
    .wr_valid_i (rdr_valid_i),
    .wr_ready_o (rdr_ready_o),
    .rd_data_o  (fifo_data),
    .rd_valid_o (fifo_valid),
    .rd_ready_i (fifo_ready)
  );

  assign start_p  = pin_rise[mlus_pkg::PIN_START];
  assign clr_p    = pin_rise[mlus_pkg::PIN_CLEAR];
  assign stop_p   = pin_rise[mlus_pkg::PIN_STOP];
  assign resume_p = pin_rise[mlus_pkg::PIN_RESUME];
  assign clr      = clr_p;
  assign op       = mlus_pkg::mlus_op_t'(ctrl_reg[mlus_pkg::CTRL_OP_LSB +: mlus_pkg::CTRL_OP_W]);

  assign wr_ctrl = reg_wr_i & (reg_addr_i == mlus_pkg::OFS_CTRL);
  assign wr_x    = reg_wr_i & (reg_addr_i == mlus_pkg::OFS_XREG);
  assign wr_m    = reg_wr_i & (reg_addr_i == mlus_pkg::OFS_MADDR);

  // Both even and odd codes of the instruction count
  assign fill_ok = ctrl_reg[mlus_pkg::CTRL_SEF]
                   & (i_reg[WW-1:1] == mlus_pkg::LOAD_CONSECUTIVE[WW-1:1]);

  assign idle_start = (state_reg == mlus_pkg::MLUS_ST_IDLE) & start_p & ~clr & ~stop_p;
  assign step_in    = (state_reg == mlus_pkg::MLUS_ST_IN_WAIT) & start_p & ~clr & ~stop_p;
  assign step_out   = ((idle_start & (op == mlus_pkg::MLUS_OP_MAN_OUT))
                      | ((state_reg == mlus_pkg::MLUS_ST_OUT_WAIT) & start_p)) & ~clr & ~stop_p;
  assign fifo_ready = (state_reg == mlus_pkg::MLUS_ST_EXT_LD) & pend_reg & ~clr & ~stop_p;
  assign ext_ld_do  = fifo_ready & fifo_valid;
  assign ext_ul_do  = (state_reg == mlus_pkg::MLUS_ST_EXT_UL) & pend_reg & ~clr & ~stop_p;
  assign fill_do    = (((state_reg == mlus_pkg::MLUS_ST_FILL) & fill_ok)
                      | (idle_start & (op == mlus_pkg::MLUS_OP_SINGLE) & fill_ok
                         & ~ctrl_reg[mlus_pkg::CTRL_REPEAT])) & ~clr & ~stop_p;
  assign ext_last   = (c_reg == '0);

  assign mem_wr    = step_in | ext_ld_do | fill_do;
  assign mem_wdata = ext_ld_do ? fifo_data : x_reg;
  assign mem_rd    = mem[m_reg];
  assign m_inc     = mem_wr | step_out | ext_ul_do;

  // Whole-word store overwrites the old contents, six bits per step
  always_ff @(posedge ref_clk_i) begin
    if (mem_wr) begin
      mem[m_reg] <= mem_wdata;
    end
  end

  always_comb begin
    state_next = state_reg;
    run_next   = 1'b0;
    unique case (state_reg)
      mlus_pkg::MLUS_ST_IDLE: begin
        if (idle_start) begin
          unique case (op)
            mlus_pkg::MLUS_OP_MAN_IN:  state_next = mlus_pkg::MLUS_ST_IN_WAIT;
            mlus_pkg::MLUS_OP_MAN_OUT: state_next = mlus_pkg::MLUS_ST_OUT_WAIT;
            mlus_pkg::MLUS_OP_EXT_LD:  state_next = mlus_pkg::MLUS_ST_EXT_LD;
            mlus_pkg::MLUS_OP_EXT_UL:  state_next = mlus_pkg::MLUS_ST_EXT_UL;
            mlus_pkg::MLUS_OP_PROGRAM: run_next = 1'b1;
            mlus_pkg::MLUS_OP_SINGLE: begin
              if (fill_ok & ctrl_reg[mlus_pkg::CTRL_REPEAT]) begin
                state_next = mlus_pkg::MLUS_ST_FILL;
              end
            end
            default: state_next = mlus_pkg::MLUS_ST_IDLE;
          endcase
        end
      end
      mlus_pkg::MLUS_ST_IN_WAIT,
      mlus_pkg::MLUS_ST_OUT_WAIT,
      mlus_pkg::MLUS_ST_FILL: begin
        if (stop_p) begin
          state_next = mlus_pkg::MLUS_ST_IDLE;
        end
      end
      mlus_pkg::MLUS_ST_EXT_LD,
      mlus_pkg::MLUS_ST_EXT_UL: begin
        if (stop_p) begin
          state_next = mlus_pkg::MLUS_ST_IDLE;
        end else if ((ext_ld_do | ext_ul_do) & ext_last) begin
          state_next = mlus_pkg::MLUS_ST_IDLE;
          run_next   = ctrl_reg[mlus_pkg::CTRL_RUN_END];
        end
      end
      default: state_next = mlus_pkg::MLUS_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i || clr) begin
      state_reg <= mlus_pkg::MLUS_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // First word of an external transfer is armed by start, later ones by resume or start
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || clr) begin
      pend_reg <= 1'b0;
    end else if (idle_start & ((op == mlus_pkg::MLUS_OP_EXT_LD) | (op == mlus_pkg::MLUS_OP_EXT_UL))) begin
      pend_reg <= 1'b1;
    end else if (((state_reg == mlus_pkg::MLUS_ST_EXT_LD) | (state_reg == mlus_pkg::MLUS_ST_EXT_UL))
                 & (resume_p | start_p)) begin
      pend_reg <= 1'b1;
    end else if (ext_ld_do | ext_ul_do) begin
      pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i || clr) begin
      ctrl_reg <= mlus_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= reg_wdata_i[mlus_pkg::CTRL_W-1:0];
    end
  end

  // Hardware transfers win over a software write in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || clr) begin
      x_reg <= '0;
    end else if (step_out | ext_ul_do) begin
      x_reg <= mem_rd;
    end else if (ext_ld_do) begin
      x_reg <= fifo_data;
    end else if (wr_x) begin
      x_reg <= reg_wdata_i[WW-1:0];
    end
  end

  // Address is whatever M holds at the step, so software may retarget it between words
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || clr) begin
      m_reg <= '0;
    end else if (m_inc) begin
      m_reg <= m_reg + 1'b1;
    end else if (wr_m) begin
      m_reg <= reg_wdata_i[AW-1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i || clr) begin
      p_reg <= '0;
      i_reg <= '0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == mlus_pkg::OFS_PCNT) begin
        p_reg <= reg_wdata_i[AW-1:0];
      end
      if (reg_addr_i == mlus_pkg::OFS_INSTR) begin
        i_reg <= reg_wdata_i[WW-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i || clr) begin
      c_reg <= '0;
    end else if ((ext_ld_do | ext_ul_do) & ~ext_last) begin
      c_reg <= c_reg - 1'b1;
    end else if (reg_wr_i && reg_addr_i == mlus_pkg::OFS_CNTDN) begin
      c_reg <= reg_wdata_i[CW-1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i || clr) begin
      dist_o      <= mlus_pkg::DIST_IDLE;
      run_o       <= 1'b0;
      run_addr_o  <= '0;
      prn_data_o  <= '0;
      prn_valid_o <= 1'b0;
    end else begin
      dist_o      <= (state_next == mlus_pkg::MLUS_ST_IN_WAIT) ? mlus_pkg::DIST_WAIT_IN
                                                               : mlus_pkg::DIST_IDLE;
      run_o       <= run_next;
      run_addr_o  <= run_next ? p_reg : run_addr_o;
      prn_valid_o <= ext_ul_do;
      prn_data_o  <= ext_ul_do ? mem_rd : prn_data_o;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || !reg_rd_i) begin
      reg_rdata_o <= '0;
    end else begin
      unique case (reg_addr_i)
        mlus_pkg::OFS_CTRL:   reg_rdata_o <= 8'(ctrl_reg);
        mlus_pkg::OFS_XREG:   reg_rdata_o <= 8'(x_reg);
        mlus_pkg::OFS_MADDR:  reg_rdata_o <= 8'(m_reg);
        mlus_pkg::OFS_PCNT:   reg_rdata_o <= 8'(p_reg);
        mlus_pkg::OFS_INSTR:  reg_rdata_o <= 8'(i_reg);
        mlus_pkg::OFS_CNTDN:  reg_rdata_o <= 8'(c_reg);
        mlus_pkg::OFS_STATUS: reg_rdata_o <= {1'b0, fifo_valid, pend_reg, dist_o, state_reg[1:0]};
        mlus_pkg::OFS_MDATA:  reg_rdata_o <= 8'(mem_rd);
      endcase
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  AST_DIST_WAIT: assert property ((state_reg == mlus_pkg::MLUS_ST_IN_WAIT) |-> dist_o == 3'h5)
    else $error("Distributor not at five while waiting for input");
  AST_STORE_ADV: assert property (step_in |=> (mem[$past(m_reg)] == $past(x_reg))
                                  && (m_reg == $past(m_reg) + 6'h01))
    else $error("Input step did not store X and advance M");
  AST_OVERWRITE: assert property (mem_wr |=> mem[$past(m_reg)] == $past(mem_wdata))
    else $error("Stored word did not replace old contents");
  AST_CLEAR: assert property (clr_p |=> (x_reg == 6'h00) && (m_reg == 6'h00) && (c_reg == 7'h00)
                              && (state_reg == mlus_pkg::MLUS_ST_IDLE))
    else $error("Clear left a register set");
  // Clear must also drop the mode, P, I and any strobe in flight
  AST_CLEAR_CFG: assert property (clr_p |=> (ctrl_reg == mlus_pkg::CTRL_RST) && (p_reg == 6'h00)
                                  && (i_reg == 6'h00) && !run_o && !prn_valid_o)
    else $error("Clear left a setting or strobe set");
  AST_M_HOLD: assert property (!m_inc && !wr_m && !clr |=> $stable(m_reg))
    else $error("Address moved without a transfer or write");
  AST_OUT_COPY: assert property (step_out |=> x_reg == $past(mem_rd) ##1 !prn_valid_o)
    else $error("Output step did not copy memory into X");
  AST_RESUME: assert property (((state_reg == mlus_pkg::MLUS_ST_EXT_UL) && !pend_reg && resume_p
                                && !clr && !stop_p) |=> ext_ul_do ##1 prn_valid_o)
    else $error("Resume pulse did not move a word");
  AST_ONE_WORD: assert property ((state_reg == mlus_pkg::MLUS_ST_EXT_UL) && !pend_reg && !resume_p
                                 && !start_p |=> !prn_valid_o ##0 !ext_ul_do)
    else $error("Word moved without a trigger");
  AST_PROG_RUN: assert property ((idle_start && (op == mlus_pkg::MLUS_OP_PROGRAM))
                                 |=> run_o && (run_addr_o == $past(p_reg)))
    else $error("Program start not issued at program counter");
  AST_FILL: assert property (((state_reg == mlus_pkg::MLUS_ST_FILL) && fill_ok && !clr && !stop_p)
                             |=> mem[$past(m_reg)] == $past(x_reg))
    else $error("Repeat fill skipped a location");

  COV_MAN_IN:  cover property (step_in ##[1:20] step_in);
  COV_EXT_LD:  cover property (ext_ld_do && ext_last);
  COV_EXT_UL:  cover property (ext_ul_do ##[1:40] ext_ul_do);
  COV_FILL:    cover property ((state_reg == mlus_pkg::MLUS_ST_FILL) [*8]);
  COV_SINGLE:  cover property (fill_do && (state_reg == mlus_pkg::MLUS_ST_IDLE));
endmodule

/* File: verif/mlus_panel_model.sv */
// Operator panel, tape reader and strip printer model
`timescale 1ns/1ps
module mlus_panel_model (
  input  wire logic                        ref_clk_i,
  input  wire logic                        srst_i,
  output logic                             start_pin_o,
  output logic                             clear_pin_o,
  output logic                             stop_pin_o,
  output logic                             resume_pin_o,
  output logic      [mlus_pkg::WORD_W-1:0] rdr_data_o,
  output logic                             rdr_valid_o,
  input  wire logic                        rdr_ready_i,
  input  wire logic [mlus_pkg::WORD_W-1:0] prn_data_i,
  input  wire logic                        prn_valid_i
);
  logic [mlus_pkg::WORD_W-1:0] rdr_q[$];
  logic [mlus_pkg::WORD_W-1:0] prn_q[$];
  logic                        auto_resume = 1'b0;
  logic                        press_go = 1'b0;
  int                          press_lane = 0;
  int                          hold_cnt;
  int                          gap;
  int                          res_cnt;

  // Switch held long enough to pass the pin filter, then released as long again
  task automatic press(input int lane);
    @(posedge ref_clk_i);
    press_lane <= lane;
    press_go   <= 1'b1;
    @(posedge ref_clk_i);
    press_go <= 1'b0;
    repeat (16) @(posedge ref_clk_i);
  endtask

  // One process owns the switch pins so a press never fights a second driver
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      hold_cnt    <= 0;
      start_pin_o <= 1'b0;
      clear_pin_o <= 1'b0;
      stop_pin_o  <= 1'b0;
    end else begin
      hold_cnt    <= press_go ? 8 : ((hold_cnt != 0) ? hold_cnt - 1 : 0);
      start_pin_o <= (hold_cnt != 0) && (press_lane == 0);
      clear_pin_o <= (hold_cnt != 0) && (press_lane == 1);
      stop_pin_o  <= (hold_cnt != 0) && (press_lane > 1);
    end
  end

  // Reader pauses between words; idle data toggles so stale words never look valid
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      gap         <= 0;
      rdr_valid_o <= 1'b0;
      rdr_data_o  <= 6'h00;
    end else if (rdr_valid_o && rdr_ready_i) begin
      void'(rdr_q.pop_front());
      gap         <= 2;
      rdr_valid_o <= 1'b0;
      rdr_data_o  <= ~rdr_data_o;
    end else if (gap != 0) begin
      gap        <= gap - 1;
      rdr_data_o <= ~rdr_data_o;
    end else if (rdr_q.size() != 0) begin
      rdr_valid_o <= 1'b1;
      rdr_data_o  <= rdr_q[0];
    end else begin
      rdr_data_o <= ~rdr_data_o;
    end
  end

  // Printer logs each word and answers with a resume pulse when enabled
  always @(posedge ref_clk_i) begin
    if (prn_valid_i) begin
      prn_q.push_back(prn_data_i);
    end
    if (srst_i) begin
      res_cnt <= 0;
    end else if (auto_resume && prn_valid_i) begin
      res_cnt <= 16;
    end else if (res_cnt != 0) begin
      res_cnt <= res_cnt - 1;
    end
    resume_pin_o <= !srst_i && (res_cnt > 8);
  end
endmodule

/* File: verif/mlus_tb_top.sv */
// Self-checking bench for the load/unload sequencer
`timescale 1ns/1ps
`define CHK(g, e, m) n_tests++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %0t %s", $time, m); end
module mlus_tb_top;
  logic       ref_clk_i = 1'b0;
  logic       srst_i;
  logic [2:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic       reg_wr_i;
  logic       reg_rd_i;
  logic [7:0] reg_rdata_o;
  logic       start_pin, clear_pin, stop_pin, resume_pin, rdr_valid, rdr_ready, prn_valid, run_o;
  logic [5:0] rdr_data, prn_data, run_addr_o;
  logic [2:0] dist_o;
  int         num_errors = 0;
  int         n_tests = 0;
  int         run_cnt = 0;

  always #4 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (run_o === 1'b1) run_cnt++;

  mlus_top i_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .start_pin_i(start_pin),
    .clear_pin_i(clear_pin), .stop_pin_i(stop_pin), .resume_pin_i(resume_pin), .rdr_data_i(rdr_data),
    .rdr_valid_i(rdr_valid), .rdr_ready_o(rdr_ready), .prn_data_o(prn_data), .prn_valid_o(prn_valid),
    .dist_o(dist_o), .run_o(run_o), .run_addr_o(run_addr_o));

  mlus_panel_model i_panel (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .start_pin_o(start_pin),
    .clear_pin_o(clear_pin), .stop_pin_o(stop_pin), .resume_pin_o(resume_pin), .rdr_data_o(rdr_data),
    .rdr_valid_o(rdr_valid), .rdr_ready_i(rdr_ready), .prn_data_i(prn_data), .prn_valid_i(prn_valid));

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // Read data is only present in the cycle after the strobe
  task automatic chk_reg(input logic [2:0] a, input logic [7:0] e, input string m);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK(reg_rdata_o, e, m)
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end

  initial begin
    int base;
    srst_i      <= 1'b1;
    reg_addr_i  <= 3'h0;
    reg_wdata_i <= 8'h00;
    reg_wr_i    <= 1'b0;
    reg_rd_i    <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    for (int a = 0; a < 6; a++) chk_reg(a[2:0], 8'h00, "register reset value");
    wr(mlus_pkg::OFS_STATUS, 8'hff);
    chk_reg(mlus_pkg::OFS_STATUS, 8'h00, "status is read only");
    $display("test reset done");

    wr(mlus_pkg::OFS_CTRL, 8'h00);
    wr(mlus_pkg::OFS_MADDR, 8'h0a);
    i_panel.press(0);
    `CHK(dist_o, 3'h5, "distributor not waiting")
    wr(mlus_pkg::OFS_XREG, 8'h2a);
    i_panel.press(0);
    chk_reg(mlus_pkg::OFS_MADDR, 8'h0b, "address not advanced");
    wr(mlus_pkg::OFS_MADDR, 8'h14);
    wr(mlus_pkg::OFS_XREG, 8'h15);
    i_panel.press(0);
    wr(mlus_pkg::OFS_XREG, 8'h33);
    i_panel.press(0);
    wr(mlus_pkg::OFS_MADDR, 8'h0a);
    wr(mlus_pkg::OFS_XREG, 8'h00);
    i_panel.press(0);
    i_panel.press(2);
    `CHK(dist_o, 3'h0, "distributor not idle after stop")
    wr(mlus_pkg::OFS_MADDR, 8'h0a);
    chk_reg(mlus_pkg::OFS_MDATA, 8'h00, "zero store did not clear");
    wr(mlus_pkg::OFS_MADDR, 8'h14);
    chk_reg(mlus_pkg::OFS_MDATA, 8'h15, "reloaded address not used");
    wr(mlus_pkg::OFS_MADDR, 8'h15);
    chk_reg(mlus_pkg::OFS_MDATA, 8'h33, "consecutive store wrong");
    $display("test manual input done");

    wr(mlus_pkg::OFS_CTRL, 8'h01);
    wr(mlus_pkg::OFS_MADDR, 8'h14);
    i_panel.press(0);
    chk_reg(mlus_pkg::OFS_XREG, 8'h15, "output word wrong");
    i_panel.press(0);
    chk_reg(mlus_pkg::OFS_XREG, 8'h33, "next output word wrong");
    i_panel.press(2);
    $display("test manual output done");

    wr(mlus_pkg::OFS_CTRL, 8'h03);
    wr(mlus_pkg::OFS_CNTDN, 8'h01);
    wr(mlus_pkg::OFS_MADDR, 8'h14);
    i_panel.auto_resume = 1'b1;
    i_panel.press(0);
    repeat (100) @(posedge ref_clk_i);
    i_panel.auto_resume = 1'b0;
    `CHK(i_panel.prn_q.size(), 2, "printed word count wrong")
    `CHK(i_panel.prn_q[0], 6'h15, "first printed word wrong")
    `CHK(i_panel.prn_q[1], 6'h33, "second printed word wrong")
    chk_reg(mlus_pkg::OFS_MADDR, 8'h16, "unload address wrong");
    $display("test external unload done");

    for (int i = 0; i < 8; i++) i_panel.rdr_q.push_back(6'h3f - 6'(i * 5));
    repeat (40) @(posedge ref_clk_i);
    `CHK(rdr_ready, 1'b0, "buffer not full after eight words")
    wr(mlus_pkg::OFS_CTRL, 8'h12);
    wr(mlus_pkg::OFS_PCNT, 8'h21);
    wr(mlus_pkg::OFS_CNTDN, 8'h07);
    wr(mlus_pkg::OFS_MADDR, 8'h28);
    base = run_cnt;
    for (int i = 0; i < 8; i++) begin
      i_panel.press(0);
      chk_reg(mlus_pkg::OFS_MADDR, 8'h29 + 8'(i), "one word per start broken");
    end
    `CHK(run_cnt, base + 1, "program not run after load")
    `CHK(run_addr_o, 6'h21, "run address wrong")
    `CHK(rdr_ready, 1'b1, "buffer not drained")
    chk_reg(mlus_pkg::OFS_STATUS, 8'h00, "not idle after last word");
    for (int i = 0; i < 8; i++) begin
      wr(mlus_pkg::OFS_MADDR, 8'h28 + 8'(i));
      chk_reg(mlus_pkg::OFS_MDATA, 8'h3f - 8'(i * 5), "loaded word wrong");
    end
    $display("test external load done");

    wr(mlus_pkg::OFS_CTRL, 8'h04);
    wr(mlus_pkg::OFS_PCNT, 8'h17);
    base = run_cnt;
    i_panel.press(0);
    `CHK(run_cnt, base + 1, "program start missing")
    `CHK(run_addr_o, 6'h17, "program start address wrong")
    $display("test program start done");

    wr(mlus_pkg::OFS_XREG, 8'h2a);
    wr(mlus_pkg::OFS_MADDR, 8'h11);
    wr(mlus_pkg::OFS_PCNT, 8'h05);
    wr(mlus_pkg::OFS_INSTR, 8'h38);
    wr(mlus_pkg::OFS_CNTDN, 8'h7f);
    wr(mlus_pkg::OFS_CTRL, 8'h2d);
    i_panel.press(1);
    for (int a = 0; a < 6; a++) chk_reg(a[2:0], 8'h00, "register survived clear");
    $display("test clear done");

    wr(mlus_pkg::OFS_INSTR, 8'h38);
    wr(mlus_pkg::OFS_XREG, 8'h07);
    wr(mlus_pkg::OFS_CTRL, 8'h2d);
    i_panel.press(0);
    repeat (100) @(posedge ref_clk_i);
    i_panel.press(2);
    for (int a = 0; a < 64; a++) begin
      wr(mlus_pkg::OFS_MADDR, 8'(a));
      chk_reg(mlus_pkg::OFS_MDATA, 8'h07, "fill missed a location");
    end
    wr(mlus_pkg::OFS_CTRL, 8'h25);
    wr(mlus_pkg::OFS_INSTR, 8'h39);
    wr(mlus_pkg::OFS_MADDR, 8'h3e);
    wr(mlus_pkg::OFS_XREG, 8'h2c);
    i_panel.press(0);
    chk_reg(mlus_pkg::OFS_MDATA, 8'h07, "single step stored twice");
    wr(mlus_pkg::OFS_MADDR, 8'h3e);
    chk_reg(mlus_pkg::OFS_MDATA, 8'h2c, "single step store wrong");
    $display("test memory fill done");
    results();
  end
endmodule
